// *** test/front_end_model.sv ***
// Behavioural comparator front end and power stage around phase 1.
`timescale 1ns/1ps
module front_end_model (
  // Clock
  input  wire logic       hclk,
  // Bench commands
  input  wire logic       fire,
  input  wire logic [3:0] ramp_len,
  // Drives from the controller
  input  wire logic       phase1_high_side_drive,
  input  wire logic       phase1_low_side_drive,
  // Comparator crossings
  output logic            ripple_cross,
  output logic            ramp_reach,
  output logic            zero_current
);
  logic [3:0] on_cnt;
  logic [3:0] off_cnt;

  initial begin
    ripple_cross = 1'b0;
    ramp_reach   = 1'b0;
    zero_current = 1'b0;
    on_cnt       = 4'h0;
    off_cnt      = 4'h0;
  end

  ////////////////////////////////////////
  // The error amplifier only climbs past the threshold while the high side is off.
  always @(posedge hclk) begin
    ripple_cross <= fire && !phase1_high_side_drive;
    on_cnt       <= phase1_high_side_drive ? on_cnt + 4'h1 : 4'h0;
    ramp_reach   <= phase1_high_side_drive && (on_cnt + 4'h1 >= ramp_len);
    if (phase1_high_side_drive) begin
      off_cnt <= 4'h0;
    end else if (off_cnt != 4'hf) begin
      off_cnt <= off_cnt + 4'h1;
    end
    // Current decays to zero a few cycles after the high side turns off.
    zero_current <= !phase1_high_side_drive && (off_cnt >= 4'h3);
  end
endmodule

// *** test/tb.sv ***
// Self-checking bench for the phase and mode selector.
`timescale 1ns/1ps
module tb;
  import phase_mode_pkg::*;
  localparam int WIN = 20;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        sel, state_low_n, slp, ilim, fire;
  logic [6:0]  code;
  logic [3:0]  rlen;
  logic        p1h, p1l, p2h, p2l, rstart, rdm, two, rx, rr, zc;
  int          err_total, comparisons, per, g, w;
  int          cyc = 0;

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  assign hready = hreadyout;

  phase_and_mode_selector #(.VT_WINDOW(WIN)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .single_phase_select(sel),
    .power_state_low_n(state_low_n), .deeper_sleep_ctrl(slp), .voltage_id_code(code),
    .current_limit(ilim), .ripple_cross(rx), .ramp_reach(rr), .zero_current(zc),
    .phase1_high_side_drive(p1h), .phase1_low_side_drive(p1l),
    .phase2_high_side_drive(p2h), .phase2_low_side_drive(p2l), .ramp_start(rstart),
    .ripple_driven_mode(rdm), .two_phase_active(two));

  front_end_model fem (
    .hclk(hclk), .fire(fire), .ramp_len(rlen), .phase1_high_side_drive(p1h),
    .phase1_low_side_drive(p1l), .ripple_cross(rx), .ramp_reach(rr), .zero_current(zc));

  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %0t %s: saw %h want %h", $time, what, seen, exp);
    end
  endtask

  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // A hang anywhere ends the run through the same report.
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      tally_and_finish;
    end
  end

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    check({31'h0, hresp}, 32'h0, "response");
  endtask

  // Long enough for the window to close and a few master ticks to pass.
  task settle;
    repeat (WIN + 3 * per + 10) @(posedge hclk);
  endtask

  task automatic pins(input logic s, input logic p, input logic d, input logic l);
    @(posedge hclk);
    sel         <= s;
    state_low_n <= p;
    slp         <= d;
    ilim        <= l;
    settle;
  endtask

  // Measures rise-to-rise spacing and high width of the phase 1 high drive.
  task automatic rise_gap(output int gap, output int width);
    logic was;
    was   = 1'b1;
    gap   = 0;
    width = 1;
    repeat (300) begin
      @(posedge hclk);
      if (p1h === 1'b1 && was === 1'b0) break;
      was = p1h;
    end
    // The rise just found must not end the spacing count at once.
    was   = 1'b1;
    repeat (300) begin
      @(posedge hclk);
      gap++;
      if (p1h === 1'b1 && was === 1'b0) break;
      if (p1h === 1'b1 && gap == width) width++;
      was = p1h;
    end
  endtask

  ////////////////////////////////////////
  task t_regs;
    logic [31:0] exp [5];
    exp = '{32'h3, 32'hfa, 32'h1, 32'h0, 32'h0};
    for (int i = 0; i < 5; i++) begin
      ahb(1'b0, 32'(4 * i), 32'h0);
      check(rd, exp[i], "reset value");
    end
    ahb(1'b1, 32'h104, 32'h55);
    ahb(1'b0, 32'h4, 32'h0);
    check(rd, 32'hfa, "out of range write");
    ahb(1'b0, 32'h20, 32'h0);
    check(rd, 32'h0, "unmapped read");
  endtask

  task t_table;
    logic [3:0] row [6];
    logic [3:0] res [6];
    row = '{4'b0100, 4'b1100, 4'b0000, 4'b0001, 4'b0110, 4'b0011};
    res = '{4'b0011, 4'b0010, 4'b0100, 4'b0010, 4'b1000, 4'b0010};
    for (int i = 0; i < 6; i++) begin
      pins(row[i][3], row[i][2], row[i][1], row[i][0]);
      ahb(1'b0, 32'h14, 32'h0);
      check(rd, {25'h0, row[i][0], row[i][3], 1'b0, res[i]}, "status");
      check({30'h0, rdm, two}, {30'h0, ~res[i][1], res[i][0]}, "mode pins");
    end
  endtask

  task t_window;
    pins(1'b0, 1'b0, 1'b0, 1'b0);
    code <= code + 7'h1;
    repeat (6) @(posedge hclk);
    ahb(1'b0, 32'h14, 32'h0);
    check({31'h0, rd[STAT_VT_BIT]}, 32'h1, "window open");
    repeat (per + 2) @(posedge hclk);
    check({30'h0, rdm, two}, 32'h1, "window forces dual pwm");
    settle;
    check({30'h0, rdm, two}, 32'h2, "window closed");
  endtask

  task automatic t_rdm(input logic dcm);
    int n;
    pins(1'b0, 1'b0, dcm, 1'b0);
    fire <= 1'b1;
    repeat (40) begin
      @(posedge hclk);
      if (rstart === 1'b1) break;
    end
    fire <= 1'b0;
    check({31'h0, rstart}, 32'h1, "ramp start");
    @(posedge hclk);
    check({30'h0, p1h, rstart}, 32'h2, "high drive up");
    n = 1;
    repeat (30) begin
      @(posedge hclk);
      if (p1h !== 1'b1) break;
      n++;
    end
    check(32'(n >= 5 && n <= 11), 32'h1, "high drive ends at ramp");
    repeat (12) @(posedge hclk);
    check({31'h0, p1l}, {31'h0, !dcm}, "low side after zero current");
  endtask

  task t_pwm;
    ahb(1'b1, 32'hc, 32'h3);
    ahb(1'b1, 32'h10, 32'h14);
    ahb(1'b1, 32'h4, 32'h8);
    per = 8;
    pins(1'b0, 1'b1, 1'b0, 1'b0);
    rise_gap(g, w);
    rise_gap(g, w);
    check(32'(g), 32'h10, "dual phase spacing");
    check(32'(w), 32'h3, "phase 1 width");
    check({31'h0, p2h}, 32'h1, "phases overlap");
    pins(1'b1, 1'b1, 1'b0, 1'b0);
    rise_gap(g, w);
    rise_gap(g, w);
    check(32'(g), 32'h8, "single phase spacing");
    ahb(1'b1, 32'h8, 32'h2);
    code <= 7'h2;
    per = 12;
    settle;
    rise_gap(g, w);
    rise_gap(g, w);
    check(32'(g), 32'hc, "period follows code");
  endtask

  // Disabling must park every drive low, low sides included.
  task t_enable;
    ahb(1'b1, 32'h0, 32'h2);
    repeat (4) @(posedge hclk);
    check({28'h0, p1h, p1l, p2h, p2l}, 32'h0, "disabled drives");
    // Without the low-side option, deeper sleep stays in continuous conduction.
    ahb(1'b1, 32'h0, 32'h1);
    pins(1'b0, 1'b0, 1'b1, 1'b0);
    ahb(1'b0, 32'h14, 32'h0);
    check(rd, 32'h4, "sleep without low-side option");
    ahb(1'b1, 32'h0, 32'h3);
  endtask

  ////////////////////////////////////////
  initial begin
    hresetn     = 1'b0;
    hsel        = 1'b0;
    haddr       = 32'h0;
    htrans      = 2'h0;
    hwrite      = 1'b0;
    hsize       = 3'h0;
    hwdata      = 32'h0;
    sel         = 1'b0;
    state_low_n = 1'b1;
    slp         = 1'b0;
    ilim        = 1'b0;
    code        = 7'h0;
    fire        = 1'b0;
    rlen        = 4'h5;
    per         = 4;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    ahb(1'b1, 32'h4, 32'h4);
    ahb(1'b1, 32'h8, 32'h0);
    // The reset period is long and must run out before the short one applies.
    repeat (260) @(posedge hclk);
    t_table;
    t_window;
    t_rdm(1'b0);
    t_rdm(1'b1);
    t_pwm;
    t_enable;
    tally_and_finish;
  end
endmodule

// *** verilog/phase_and_mode_selector.sv ***
// Phase count and control method selection with phase drive sequencing.
`timescale 1ns/1ps
module phase_and_mode_selector #(
  parameter int unsigned VT_WINDOW = phase_mode_pkg::VT_WINDOW_CYCLES
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // State pins
  input  wire logic        single_phase_select,
  input  wire logic        power_state_low_n,
  input  wire logic        deeper_sleep_ctrl,
  input  wire logic [6:0]  voltage_id_code,
  // Analog front end crossings
  input  wire logic        current_limit,
  input  wire logic        ripple_cross,
  input  wire logic        ramp_reach,
  input  wire logic        zero_current,
  // Drives and mode
  output logic             phase1_high_side_drive,
  output logic             phase1_low_side_drive,
  output logic             phase2_high_side_drive,
  output logic             phase2_low_side_drive,
  output logic             ramp_start,
  output logic             ripple_driven_mode,
  output logic             two_phase_active
);
  import phase_mode_pkg::*;

  localparam logic [19:0] VT_LOAD = 20'(VT_WINDOW);

  logic [SYNC_WIDTH-1:0] sync_bus;
  logic [6:0]  code_s;
  logic        sel_s;
  logic        pwr_s;
  logic        dslp_s;
  logic        ilim_s;
  logic        ripple_s;
  logic        ramp_s;
  logic        zero_s;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation.

  pin_sync #(
    .WIDTH (SYNC_WIDTH)
  ) u_sync (  // [R15]
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in ({voltage_id_code, single_phase_select, power_state_low_n,
                deeper_sleep_ctrl, current_limit, ripple_cross, ramp_reach,
                zero_current}),
    .sync_reg (sync_bus)
  );

  assign code_s   = sync_bus[13:7];
  assign sel_s    = sync_bus[6];
  assign pwr_s    = sync_bus[5];
  assign dslp_s   = sync_bus[4];
  assign ilim_s   = sync_bus[3];
  assign ripple_s = sync_bus[2];
  assign ramp_s   = sync_bus[1];
  assign zero_s   = sync_bus[0];

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite register slave, zero wait states.

  logic        ctrl_en_reg;
  logic        ctrl_dcm_reg;
  logic [15:0] base_reg;
  logic [7:0]  step_reg;
  logic [15:0] duty1_reg;
  logic [15:0] duty2_reg;
  logic        wr_pend_reg;
  logic [7:0]  wr_addr_reg;
  logic        access;
  logic        word_ok;
  logic [31:0] read_next;
  logic [6:0]  status_bits;

  assign access  = hsel && htrans[1] && hready;
  assign word_ok = (haddr[31:8] == 24'h000000) && (hsize == 3'b010);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata      <= 32'h00000000;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end else begin
      wr_pend_reg <= access && hwrite && word_ok;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      if (access) begin
        wr_addr_reg <= haddr[7:0];
      end
      if (access && !hwrite) begin
        hrdata <= read_next;
      end
    end
  end

  always_comb begin
    read_next = 32'h00000000;
    if (word_ok) begin
      case (haddr[7:0])
        CTRL_OFFSET:   read_next = {30'h0, ctrl_dcm_reg, ctrl_en_reg};
        BASE_OFFSET:   read_next = {16'h0000, base_reg};
        STEP_OFFSET:   read_next = {24'h000000, step_reg};
        DUTY1_OFFSET:  read_next = {16'h0000, duty1_reg};
        DUTY2_OFFSET:  read_next = {16'h0000, duty2_reg};
        STATUS_OFFSET: read_next = {25'h0, status_bits};
        default:       read_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_en_reg  <= CTRL_RESET[CTRL_ENABLE_BIT];
      ctrl_dcm_reg <= CTRL_RESET[CTRL_DCM_BIT];
      base_reg     <= BASE_RESET;
      step_reg     <= STEP_RESET;
      duty1_reg    <= DUTY_RESET;
      duty2_reg    <= DUTY_RESET;
    end else if (wr_pend_reg) begin
      case (wr_addr_reg)
        CTRL_OFFSET: begin
          ctrl_en_reg  <= hwdata[CTRL_ENABLE_BIT];
          ctrl_dcm_reg <= hwdata[CTRL_DCM_BIT];
        end
        BASE_OFFSET:  base_reg  <= hwdata[15:0];
        STEP_OFFSET:  step_reg  <= hwdata[7:0];
        DUTY1_OFFSET: duty1_reg <= hwdata[15:0];
        DUTY2_OFFSET: duty2_reg <= hwdata[15:0];
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master clock. A higher code means a lower voltage, so the period grows
  // with the code and is recomputed only when a period ends.

  logic [15:0] mclk_cnt_reg;
  logic [15:0] period_calc;
  logic [15:0] period_use;
  logic        mtick_reg;

  assign period_calc = base_reg + 16'(code_s) * 16'(step_reg);  // [R12]
  assign period_use  = (period_calc < PERIOD_MIN) ? PERIOD_MIN : period_calc;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mclk_cnt_reg <= 16'h0000;
      mtick_reg    <= 1'b0;
    end else if (mclk_cnt_reg == 16'h0000) begin
      mclk_cnt_reg <= period_use - 16'h0001;
      mtick_reg    <= 1'b1;
    end else begin
      mclk_cnt_reg <= mclk_cnt_reg - 16'h0001;
      mtick_reg    <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transition window on any code change or sleep entry and exit.

  logic [6:0]  code_prev_reg;
  logic        dslp_prev_reg;
  logic [19:0] vt_cnt_reg;
  logic        code_change;
  logic        vt_active;

  assign code_change = (code_s != code_prev_reg) || (dslp_s != dslp_prev_reg);
  assign vt_active   = (vt_cnt_reg != 20'h00000);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      code_prev_reg <= 7'h00;
      dslp_prev_reg <= 1'b0;
      vt_cnt_reg    <= 20'h00000;
    end else begin
      code_prev_reg <= code_s;
      dslp_prev_reg <= dslp_s;
      if (code_change) begin
        vt_cnt_reg <= VT_LOAD;  // [R8]
      end else if (vt_active) begin
        vt_cnt_reg <= vt_cnt_reg - 20'h00001;
      end
    end
  end

  vt_open_a: assert property (@(posedge hclk) disable iff (!hresetn)
    code_change |=> (vt_cnt_reg == VT_LOAD)) else $error("window not opened");  // [R8]

  ////////////////////////////////////////////////////////////////////////////
  // Phase count and method, decided once per master tick.

  mode_type    mode_reg;
  mode_type    mode_next;
  logic        two_next;
  logic        rdm_mode;
  logic        pwm_mode;

  always_comb begin
    mode_next = MODE_PWM_CCM;
    two_next  = 1'b0;
    if (vt_active || (pwr_s && !dslp_s)) begin  // [R14]
      mode_next = MODE_PWM_CCM;  // [R4]
      two_next  = !sel_s;  // [R1] [R2] [R13]
    end else if (ilim_s) begin
      mode_next = MODE_PWM_CCM;  // [R6] [R7] [R14]
    end else if (dslp_s && ctrl_dcm_reg) begin
      mode_next = MODE_RDM_DCM;  // [R7]
    end else begin
      mode_next = MODE_RDM_CCM;  // [R5] [R6]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_reg <= MODE_PWM_CCM;
      two_phase_active <= 1'b0;
    end else if (mtick_reg) begin
      mode_reg <= mode_next;
      two_phase_active <= two_next;
    end
  end

  assign rdm_mode = (mode_reg != MODE_PWM_CCM);
  assign pwm_mode = (mode_reg == MODE_PWM_CCM);
  assign status_bits = {ilim_s, sel_s, vt_active, mode_reg, two_phase_active};

  sel_single_a: assert property (@(posedge hclk) disable iff (!hresetn)
    mtick_reg && sel_s |=> !two_phase_active) else $error("two phases with select");  // [R1]
  dual_vt_a: assert property (@(posedge hclk) disable iff (!hresetn)
    mtick_reg && !sel_s && vt_active |=> two_phase_active && (mode_reg == MODE_PWM_CCM))
    else $error("window not dual PWM");  // [R4]
  light_single_a: assert property (@(posedge hclk) disable iff (!hresetn)
    mtick_reg && !vt_active && (!pwr_s || dslp_s) |=> !two_phase_active)
    else $error("light load kept two phases");  // [R5]
  awake_mode_a: assert property (@(posedge hclk) disable iff (!hresetn)
    mtick_reg && !vt_active && !pwr_s && !dslp_s |=>
    (mode_reg == (ilim_s ? MODE_PWM_CCM : MODE_RDM_CCM))) else $error("bad light mode");  // [R6]
  sleep_mode_a: assert property (@(posedge hclk) disable iff (!hresetn)
    mtick_reg && !vt_active && dslp_s && ctrl_dcm_reg |=>
    (mode_reg == (ilim_s ? MODE_PWM_CCM : MODE_RDM_DCM))) else $error("bad sleep mode");  // [R7]

  ////////////////////////////////////////////////////////////////////////////
  // Fixed-clock PWM: ticks alternate between the phases in dual operation,
  // so each phase runs at the master rate divided by the phase count.

  logic        phase_sel_reg;
  logic        start1;
  logic        start2;
  logic        pwm1_drive;
  logic        pwm2_drive;

  assign start1 = mtick_reg && (!two_phase_active || !phase_sel_reg);  // [R11]
  assign start2 = mtick_reg && two_phase_active && phase_sel_reg;  // [R11]

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_sel_reg <= 1'b0;
    end else if (mtick_reg) begin
      phase_sel_reg <= two_phase_active && !phase_sel_reg;
    end
  end

  // Each phase owns its timer, so both drives may be high at once.
  phase_pwm #(
    .WIDTH (16)
  ) u_phase1 (  // [R3]
    .hclk      (hclk),
    .hresetn   (hresetn),
    .run       (ctrl_en_reg && pwm_mode),
    .start     (start1),
    .duty      (duty1_reg),
    .drive_reg (pwm1_drive)
  );

  phase_pwm #(
    .WIDTH (16)
  ) u_phase2 (  // [R3]
    .hclk      (hclk),
    .hresetn   (hresetn),
    .run       (ctrl_en_reg && pwm_mode && two_phase_active),
    .start     (start2),
    .duty      (duty2_reg),
    .drive_reg (pwm2_drive)
  );

  dual_drive_a: assert property (@(posedge hclk) disable iff (!hresetn)
    start2 && ctrl_en_reg && !wr_pend_reg && (duty2_reg != 16'h0000) && two_next &&
    (mode_next == MODE_PWM_CCM) |-> ##2 phase2_high_side_drive)
    else $error("phase two did not start");  // [R3]

  ////////////////////////////////////////////////////////////////////////////
  // Ripple-driven sequencing of the phase-1 high side.

  logic        ripple_prev_reg;
  logic        ripple_rise;
  logic        rdm_high_reg;
  logic        zc_off_reg;

  assign ripple_rise = ripple_s && !ripple_prev_reg;

  // Ramp reached wins over a new crossing so the drive never sticks high.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ripple_prev_reg <= 1'b0;
      rdm_high_reg    <= 1'b0;
      ramp_start      <= 1'b0;
    end else begin
      ripple_prev_reg <= ripple_s;
      ramp_start      <= rdm_mode && ctrl_en_reg && ripple_rise && !ramp_s;  // [R9]
      if (!rdm_mode || ramp_s) begin
        rdm_high_reg <= 1'b0;  // [R10]
      end else if (ripple_rise) begin
        rdm_high_reg <= 1'b1;  // [R9]
      end
    end
  end

  // The low side stays off from the zero crossing until the next pulse.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      zc_off_reg <= 1'b0;
    end else if (mode_reg != MODE_RDM_DCM || rdm_high_reg) begin
      zc_off_reg <= 1'b0;
    end else if (zero_s) begin
      zc_off_reg <= 1'b1;  // [R7]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output drives; each low side complements its high side while its phase runs, except phase 1 low after zero current.

  logic        p1_high_next;
  logic        p2_high_next;

  assign p1_high_next = ctrl_en_reg && (rdm_mode ? rdm_high_reg : pwm1_drive);
  assign p2_high_next = ctrl_en_reg && pwm_mode && two_phase_active && pwm2_drive;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase1_high_side_drive <= 1'b0;
      phase1_low_side_drive  <= 1'b0;
      phase2_high_side_drive <= 1'b0;
      phase2_low_side_drive  <= 1'b0;
      ripple_driven_mode     <= 1'b0;
    end else begin
      phase1_high_side_drive <= p1_high_next;
      phase1_low_side_drive  <= ctrl_en_reg && !p1_high_next && !zc_off_reg;  // [R7]
      phase2_high_side_drive <= p2_high_next;
      phase2_low_side_drive  <= ctrl_en_reg && pwm_mode && two_phase_active &&
                                !p2_high_next;
      ripple_driven_mode     <= rdm_mode;
    end
  end

  rdm_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl_en_reg && !wr_pend_reg && rdm_mode && !mtick_reg && ripple_rise && !ramp_s
    |-> ##2 phase1_high_side_drive) else $error("ripple pulse missed");  // [R9]
  rdm_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rdm_mode && !mtick_reg && ramp_s |-> ##2 !phase1_high_side_drive)
    else $error("ramp did not end pulse");  // [R10]
  zc_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
    zc_off_reg |=> !phase1_low_side_drive) else $error("low side on after zero");  // [R7]

endmodule

// *** verilog/phase_mode_pkg.sv ***
// Shared constants and types for the phase and mode selector.
// Operation
// R1: Single-phase select high forces exactly one phase.
// R2: Select low: dual default, phases follow load.
// R3: Dual phases timed independently, overlap allowed.
// R4: Transition or heavy load: two-phase PWM CCM.
// R5: Light load drops to one phase.
// R6: Light, awake: ripple CCM, or PWM on limit.
// R7: Deeper sleep: ripple with zero-current low-side off.
// R8: Code or sleep change opens transition window.
// R9: Ripple crossing starts ramp, raises high drive.
// R10: Ramp reaching level drops high drive.
// R11: PWM phases run at master divided by phases.
// R12: Master period fixed per code, longer lower.
// R13: Outside party drives the single-phase select level.
// R14: Re-decide each master tick; window, limit win.
// R15: Comparator crossings are synchronised before use.
package phase_mode_pkg;

  // Timing.
  localparam int unsigned CLK_MHZ          = 125;
  localparam int unsigned VT_WINDOW_US     = 100;
  localparam int unsigned VT_WINDOW_CYCLES = VT_WINDOW_US * CLK_MHZ;

  // Register byte offsets.
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] BASE_OFFSET   = 8'h04;
  localparam logic [7:0] STEP_OFFSET   = 8'h08;
  localparam logic [7:0] DUTY1_OFFSET  = 8'h0c;
  localparam logic [7:0] DUTY2_OFFSET  = 8'h10;
  localparam logic [7:0] STATUS_OFFSET = 8'h14;

  // Field positions.
  localparam int CTRL_ENABLE_BIT  = 0;
  localparam int CTRL_DCM_BIT     = 1;
  localparam int STAT_TWO_BIT     = 0;
  localparam int STAT_MODE_LSB    = 1;
  localparam int STAT_VT_BIT      = 4;
  localparam int STAT_SEL_BIT     = 5;
  localparam int STAT_ILIM_BIT    = 6;

  // Reset values.
  localparam logic [1:0]  CTRL_RESET  = 2'h3;
  localparam logic [15:0] BASE_RESET  = 16'h00fa;
  localparam logic [7:0]  STEP_RESET  = 8'h01;
  localparam logic [15:0] DUTY_RESET  = 16'h0000;
  localparam logic [15:0] PERIOD_MIN  = 16'h0002;

  // Synchroniser width: code, four state pins and three comparator crossings.
  localparam int SYNC_WIDTH = 14;

  typedef enum logic [2:0] {
    MODE_PWM_CCM = 3'b001,
    MODE_RDM_CCM = 3'b010,
    MODE_RDM_DCM = 3'b100
  } mode_type;

endpackage

// *** verilog/phase_pwm.sv ***
// One phase of fixed-clock PWM: rises on start, falls after duty cycles.
`timescale 1ns/1ps
module phase_pwm #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // Control
  input  wire logic             run,
  input  wire logic             start,
  input  wire logic [WIDTH-1:0] duty,
  // Drive
  output logic                  drive_reg
);
  logic [WIDTH-1:0] count_reg;

  // A duty longer than the phase period keeps the drive high across the
  // next start, which is how full duty is reached.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_reg <= '0;
      drive_reg <= 1'b0;
    end else if (!run) begin
      count_reg <= '0;
      drive_reg <= 1'b0;
    end else if (start) begin
      count_reg <= {{(WIDTH-1){1'b0}}, 1'b1};
      drive_reg <= (duty != '0);
    end else begin
      if (count_reg != '1) begin
        count_reg <= count_reg + 1'b1;
      end
      if (count_reg >= duty) begin
        drive_reg <= 1'b0;
      end
    end
  end
endmodule

// *** verilog/pin_sync.sv ***
// Two-stage synchroniser for a group of asynchronous inputs.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // Asynchronous levels and their synchronised copies
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_reg
);
  logic [WIDTH-1:0] stage1_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage1_reg <= '0;
      sync_reg   <= '0;
    end else begin
      stage1_reg <= async_in;
      sync_reg   <= stage1_reg;
    end
  end
endmodule
